/* dsoc_pkg.sv */
// package: constants and state encoding for the decoder stream and output control
package dsoc_pkg;
   // frame buffers and result index coding
   localparam int FB_COUNT = 16;
   localparam int FB_IDX_W = 4;
   localparam int IDX_W = 16;
   localparam logic [15:0] IDX_END_OF_SEQ = 16'hFFFF;
   localparam logic [15:0] IDX_FRAME_SKIP = 16'hFFFE;
   localparam logic [15:0] IDX_NOT_YET = 16'hFFFD;
   localparam logic [15:0] IDX_NO_DECODE = 16'hFFFF;
   localparam int UPCOMING_N = 3;
   localparam logic [4:0] REORDER_MAX_HOLD = 5'h11;
   // circular stream buffer, byte pointers
   localparam int PTR_W = 20;
   localparam logic [PTR_W:0] STREAM_BUF_BYTES = 21'h080000;
   localparam logic [PTR_W-1:0] WORD_BYTES = 20'h00004;
   localparam logic [PTR_W-1:0] PTR_RESET = 20'h00000;
   // interrupt enable and pre-scan
   localparam int IRQ_EN_W = 8;
   localparam int IRQ_PIC_DONE_BIT = 3;
   localparam logic PRESCAN_MODE_FULL_ONLY = 1'b0;
   // stream word fifo
   localparam int FIFO_W = 32;
   localparam int FIFO_DEPTH = 32;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CHECK = 2'b01,
      ST_DECODE = 2'b10,
      ST_DONE = 2'b11
   } dsoc_state_t;
endpackage : dsoc_pkg

/* dsoc_fifo.sv */
// stream word fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dsoc_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // draining side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_idx, rd_idx, next_wr_idx, next_rd_idx;
   logic [AW:0] count, next_count;
   logic push, pop;

   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_idx = push ? AW'(wr_idx + 1'b1) : wr_idx;
      next_rd_idx = pop ? AW'(rd_idx + 1'b1) : rd_idx;
      next_count = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count <= '0;
      end else begin
         wr_idx <= next_wr_idx;
         rd_idx <= next_rd_idx;
         count <= next_count;
      end
   end

   // storage has no reset; contents are only read behind a valid count
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_idx] <= in_data;
      end
   end

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_idx];
endmodule : dsoc_fifo
`default_nettype wire

/* dsoc_ctrl.sv */
// decoder stream buffer pointers, decode sequencing, result reporting and display flags
`timescale 1ns/1ps
`default_nettype none
//Contract
// R1: one query returns read pointer, write pointer and free space together.
// R2: host writes at most the free space and wraps at the buffer end.
// R3: reported byte count advances the write pointer, wrapping past the end.
// R4: host finishes stream transfers before reporting the byte count.
// R5: file-play mode empties the stream buffer after every picture decode.
// R6: busy status stays asserted while a picture decode is in progress.
// R7: decode completion raises the interrupt enabled by enable bit 3.
// R8: no new decode starts until previous results are fetched; fetch releases.
// R9: display index names the buffer to show next, may differ from decoded.
// R10: no display gives -1 end of sequence, -2 frame skip, -3 temporary.
// R11: reordering may withhold display up to 17 frames, index negative meanwhile.
// R12: no free frame buffer reports decoded index -1 (0xFFFF).
// R13: flushing, skip option or header error also report decoded index -1.
// R14: full picture flag shows whole picture present; 0 means no decode.
// R15: host checks the full picture flag first under pre-scan mode 0.
// R16: host disables pre-scan and reruns when zero with a full buffer.
// R17: four crop offsets reported, zero when cropping is off.
// R18: up to three upcoming buffer indices for the next decode start.
// R19: report per frame whether parameter-set or slice save buffer was short.
// R20: display flag set when returned as display index; flagged buffers never written.
// R21: without a free frame buffer, finish at once with decoded index -1; with flush_mode set the code still starts the decode.
// R22: host clears a display flag only after displaying that buffer.
// R23: stream size report of 0 ends the current decode promptly.
// R24: reset clears flags, rewinds pointers, drops busy and interrupt.
module dsoc_ctrl
   import dsoc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host commands
   input wire logic start_picture_decode,
   input wire logic fetch_decode_results,
   input wire logic query_stream_buffer,
   input wire logic advance_write_pointer,
   input wire logic [PTR_W-1:0] advance_bytes,
   input wire logic report_stream_size,
   input wire logic [PTR_W-1:0] report_size,
   input wire logic release_display_buffer,
   input wire logic [FB_IDX_W-1:0] release_index,
   // host configuration
   input wire logic [IRQ_EN_W-1:0] int_enable,
   input wire logic file_play_mode,
   input wire logic flush_mode,
   input wire logic skip_picture,
   input wire logic stream_end,
   input wire logic prescan_enable,
   input wire logic prescan_mode,
   // stream words fetched from the buffer
   input wire logic fill_valid,
   input wire logic [FIFO_W-1:0] fill_data,
   output logic fill_ready,
   // stream words to the datapath
   output logic core_valid,
   output logic [FIFO_W-1:0] core_data,
   input wire logic core_ready,
   // datapath handshake and findings
   output logic dp_start,
   output logic dp_abort,
   output logic [FB_IDX_W-1:0] dp_target_index,
   input wire logic dp_done,
   input wire logic dp_full_picture,
   input wire logic dp_header_error,
   input wire logic dp_display_valid,
   input wire logic [FB_IDX_W-1:0] dp_display_index,
   input wire logic dp_display_drained,
   input wire logic dp_crop_on,
   input wire logic [4*IDX_W-1:0] dp_crop_offsets,
   input wire logic dp_ps_short,
   input wire logic dp_slice_short,
   // stream buffer query answer
   output logic query_valid,
   output logic [PTR_W-1:0] read_ptr,
   output logic [PTR_W-1:0] write_ptr,
   output logic [PTR_W-1:0] free_space,
   // status and results
   output logic engine_busy_status,
   output logic completion_irq,
   output logic results_valid,
   output logic [IDX_W-1:0] display_buffer_index,
   output logic [IDX_W-1:0] decoded_buffer_index,
   output logic full_picture_present,
   output logic [4*IDX_W-1:0] crop_window_offsets,
   output logic [UPCOMING_N*IDX_W-1:0] upcoming_buffer_indices,
   output logic ps_buffer_short,
   output logic slice_buffer_short,
   output logic [FB_COUNT-1:0] display_flags,
   output logic [4:0] withheld_count
);
   dsoc_state_t state, next_state;
   logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr, fill_bytes;
   logic [PTR_W:0] wr_sum;
   logic allow_fill, next_allow_fill, fifo_in_ready, fifo_push;
   logic finish, decode_ok, disp_set, free_any;
   logic [FB_IDX_W-1:0] free_idx, target;
   logic [FB_COUNT-1:0] next_flags;
   logic [IDX_W-1:0] res_disp;
   logic [UPCOMING_N*IDX_W-1:0] upcoming_calc;

   // stream pointer arithmetic; a wrapped sum is folded back once
   always_comb begin
      wr_sum = (PTR_W+1)'({1'b0, wr_ptr} + {1'b0, advance_write_pointer ? advance_bytes : report_size});
      if (wr_sum >= STREAM_BUF_BYTES) begin
         wr_sum = (PTR_W+1)'(wr_sum - STREAM_BUF_BYTES);
      end
      if (wr_ptr >= rd_ptr) begin
         fill_bytes = PTR_W'(wr_ptr - rd_ptr);
      end else begin
         fill_bytes = PTR_W'(STREAM_BUF_BYTES + {1'b0, wr_ptr} - {1'b0, rd_ptr});
      end
      fifo_push = fill_valid && fill_ready;
      next_wr_ptr = wr_ptr;
      if (advance_write_pointer || (report_stream_size && report_size != '0)) begin
         next_wr_ptr = wr_sum[PTR_W-1:0]; // [R3]
      end
      next_rd_ptr = rd_ptr;
      if (fifo_push) begin
         next_rd_ptr = (rd_ptr + WORD_BYTES >= STREAM_BUF_BYTES[PTR_W-1:0]) ?
                       PTR_W'(rd_ptr + WORD_BYTES - STREAM_BUF_BYTES[PTR_W-1:0]) : PTR_W'(rd_ptr + WORD_BYTES);
      end
      if (finish && file_play_mode) begin
         next_rd_ptr = wr_ptr; // [R5]
      end
      // fetch only whole words that the host has already declared written
      next_allow_fill = (next_state == ST_DECODE) && (fill_bytes > WORD_BYTES);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= PTR_RESET; // [R24]
         rd_ptr <= PTR_RESET;
         allow_fill <= 1'b0;
         query_valid <= 1'b0;
         read_ptr <= PTR_RESET;
         write_ptr <= PTR_RESET;
         free_space <= PTR_RESET;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         allow_fill <= next_allow_fill;
         query_valid <= query_stream_buffer;
         if (query_stream_buffer) begin
            read_ptr <= rd_ptr; // [R1]
            write_ptr <= wr_ptr;
            free_space <= PTR_W'(STREAM_BUF_BYTES - {1'b0, fill_bytes} - 1'b1);
         end
      end
   end

   // while fetching is allowed, reads stall only when the fifo is full, so with the datapath stopped the fifo really fills
   assign fill_ready = allow_fill && fifo_in_ready;

   dsoc_fifo #(
      .W(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(fill_valid && allow_fill),
      .in_data(fill_data),
      .in_ready(fifo_in_ready),
      .out_valid(core_valid),
      .out_data(core_data),
      .out_ready(core_ready)
   );

   // lowest unflagged frame buffer, or buffer 0 when every buffer waits for display
   always_comb begin
      free_any = 1'b0;
      free_idx = '0;
      for (int i = FB_COUNT - 1; i >= 0; i--) begin
         if (!display_flags[i]) begin
            free_any = 1'b1; // [R20]
            free_idx = FB_IDX_W'(i);
         end
      end
   end

   // decode sequencing
   always_comb begin
      next_state = state;
      finish = 1'b0;
      decode_ok = 1'b0;
      case (state)
         ST_IDLE: begin
            if (start_picture_decode) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (!free_any && !flush_mode) begin
               finish = 1'b1; // [R21]
               next_state = ST_DONE;
            end else if (prescan_enable && prescan_mode == PRESCAN_MODE_FULL_ONLY && !dp_full_picture) begin
               finish = 1'b1; // [R14]
               next_state = ST_DONE;
            end else begin
               next_state = ST_DECODE;
            end
         end
         ST_DECODE: begin
            if (dp_done || (report_stream_size && report_size == '0)) begin
               finish = 1'b1; // [R23]
               decode_ok = 1'b1;
               next_state = ST_DONE;
            end
         end
         ST_DONE: begin
            if (fetch_decode_results) begin
               next_state = ST_IDLE; // [R8]
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // result words captured at completion
   always_comb begin
      disp_set = decode_ok && dp_display_valid;
      if (disp_set) begin
         res_disp = IDX_W'(dp_display_index); // [R9]
      end else if (stream_end && dp_display_drained) begin
         res_disp = IDX_END_OF_SEQ; // [R10]
      end else if (skip_picture) begin
         res_disp = IDX_FRAME_SKIP;
      end else begin
         res_disp = IDX_NOT_YET; // [R11]
      end
      upcoming_calc = {UPCOMING_N{IDX_NO_DECODE}};
      for (int i = 0, n = 0; i < FB_COUNT; i++) begin
         if (!next_flags[i] && n < UPCOMING_N) begin
            upcoming_calc[n*IDX_W +: IDX_W] = IDX_W'(i); // [R18]
            n++;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         engine_busy_status <= 1'b0; // [R24]
         completion_irq <= 1'b0;
         results_valid <= 1'b0;
         dp_start <= 1'b0;
         dp_abort <= 1'b0;
         dp_target_index <= '0;
         target <= '0;
         display_buffer_index <= IDX_NOT_YET;
         decoded_buffer_index <= IDX_NO_DECODE;
         full_picture_present <= 1'b0;
         crop_window_offsets <= '0;
         upcoming_buffer_indices <= {UPCOMING_N{IDX_NO_DECODE}};
         ps_buffer_short <= 1'b0;
         slice_buffer_short <= 1'b0;
         withheld_count <= 5'h00;
      end else begin
         state <= next_state;
         engine_busy_status <= (next_state == ST_CHECK) || (next_state == ST_DECODE); // [R6]
         results_valid <= (next_state == ST_DONE);
         dp_start <= (state == ST_CHECK) && (next_state == ST_DECODE);
         dp_abort <= (state == ST_DECODE) && report_stream_size && report_size == '0;
         if (state == ST_CHECK) begin
            target <= free_idx;
            dp_target_index <= free_idx;
         end
         if (finish) begin
            completion_irq <= int_enable[IRQ_PIC_DONE_BIT]; // [R7]
            display_buffer_index <= decode_ok ? res_disp : IDX_NOT_YET;
            // flush, skip and header error leave no decoded frame behind
            decoded_buffer_index <= (!decode_ok || flush_mode || skip_picture || dp_header_error) ?
                                    IDX_NO_DECODE : IDX_W'(target); // [R12] [R13]
            full_picture_present <= decode_ok; // [R14]
            crop_window_offsets <= (decode_ok && dp_crop_on) ? dp_crop_offsets : '0; // [R17]
            upcoming_buffer_indices <= upcoming_calc;
            ps_buffer_short <= decode_ok && dp_ps_short; // [R19]
            slice_buffer_short <= decode_ok && dp_slice_short;
            if (disp_set) begin
               withheld_count <= 5'h00;
            end else if (decode_ok && !flush_mode && withheld_count < REORDER_MAX_HOLD) begin
               withheld_count <= 5'(withheld_count + 1'b1); // [R11]
            end
         end else if (state == ST_DONE && fetch_decode_results) begin
            completion_irq <= 1'b0;
         end
      end
   end

   // one flag per frame buffer; a set in the same cycle as a release wins
   for (genvar g = 0; g < FB_COUNT; g++) begin : g_flag
      always_comb begin
         next_flags[g] = display_flags[g];
         if (release_display_buffer && release_index == FB_IDX_W'(g)) begin
            next_flags[g] = 1'b0; // [R22]
         end
         if (disp_set && dp_display_index == FB_IDX_W'(g)) begin
            next_flags[g] = 1'b1; // [R20]
         end
      end
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            display_flags[g] <= 1'b0;
         end else begin
            display_flags[g] <= next_flags[g];
         end
      end
   end

   a_query_answer: assert property (@(posedge clk) disable iff (rst) query_stream_buffer |=> query_valid && write_ptr == $past(wr_ptr) && read_ptr == $past(rd_ptr)) else $error("query answer wrong"); // [R1]
   a_wrptr_wrap: assert property (@(posedge clk) disable iff (rst) advance_write_pointer |=> wr_ptr == PTR_W'(({1'b0, $past(wr_ptr)} + {1'b0, $past(advance_bytes)}) % STREAM_BUF_BYTES)) else $error("write pointer advance wrong"); // [R3]
   a_fileplay_empty: assert property (@(posedge clk) disable iff (rst) finish && file_play_mode |=> rd_ptr == $past(wr_ptr)) else $error("file play buffer not emptied"); // [R5]
   a_busy_hold: assert property (@(posedge clk) disable iff (rst) state == ST_DECODE |-> engine_busy_status) else $error("busy low during decode"); // [R6]
   a_irq_bit3: assert property (@(posedge clk) disable iff (rst) finish |=> completion_irq == $past(int_enable[IRQ_PIC_DONE_BIT])) else $error("irq not gated by bit 3"); // [R7]
   a_no_restart: assert property (@(posedge clk) disable iff (rst) state == ST_DONE && !fetch_decode_results |=> state == ST_DONE && !engine_busy_status) else $error("decode restarted before fetch"); // [R8]
   a_no_buffer: assert property (@(posedge clk) disable iff (rst) state == ST_CHECK && !free_any && !flush_mode |=> state == ST_DONE && decoded_buffer_index == IDX_NO_DECODE && !dp_start) else $error("no free buffer not reported"); // [R21]
   a_flag_set: assert property (@(posedge clk) disable iff (rst) disp_set |=> display_flags[$past(dp_display_index)] && display_buffer_index == IDX_W'($past(dp_display_index))) else $error("display flag not set"); // [R20]
   a_abort_end: assert property (@(posedge clk) disable iff (rst) state == ST_DECODE && report_stream_size && report_size == '0 |=> state == ST_DONE && dp_abort) else $error("zero size did not end decode"); // [R23]
endmodule : dsoc_ctrl
`default_nettype wire

/* dsoc_dp_model.sv */
// datapath stand-in: answers decode starts, drains stream words
`timescale 1ns/1ps
`default_nettype none
module dsoc_dp_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // decode handshake
   input wire logic dp_start,
   input wire logic dp_abort,
   output logic dp_done,
   // stream words
   output logic core_ready,
   // test controls
   input wire logic slow,
   input wire logic stall
);
   int cnt;
   // stalling holds words back so the fifo can fill up
   assign core_ready = !stall;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         dp_done <= 1'b0;
      end else begin
         dp_done <= (cnt == 1);
         if (dp_start) begin
            cnt <= slow ? 120 : 3;
         end else if (dp_abort) begin
            cnt <= 0; // an abort clears the count; done still follows if the count stood at 1
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule : dsoc_dp_model
`default_nettype wire

/* test_decoder_stream_and_output_control.sv */
// self-checking bench for the decoder stream and output control
`timescale 1ns/1ps
`default_nettype none
module test_decoder_stream_and_output_control;
   import dsoc_pkg::*;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
   typedef struct packed {
      logic [15:0] disp; logic [15:0] dec; logic fp; logic irq; logic [63:0] crop; logic ps; logic sl;
      logic [15:0] flags; logic [47:0] up; logic [4:0] wh; logic full;
   } dsoc_exp_t;
   logic clk = 0, rst = 1, start = 0, fetch = 0, query = 0, adv = 0, rep = 0, rel = 0;
   logic [PTR_W-1:0] adv_b = 0, rep_b = 0;
   logic [3:0] rel_i = 0, di = 0, tgt_m = 0;
   logic [7:0] int_en = 8'h08;
   logic fplay = 0, flush = 0, skip = 0, send = 0, pse = 0, psm = 0, fill_v = 0, slow = 0, stall = 0;
   logic fullp = 1, hdr = 0, dv = 0, drained = 0, crop_on = 0, ps = 0, sl = 0, rv_d = 0;
   logic [31:0] fill_d = 0;
   logic [63:0] crop = 0;
   wire fill_r, core_v, core_r, dps, dpa, dpd, qv, busy, irq, rv, fpp, pss, sls;
   wire [31:0] core_d;
   wire [3:0] tgt;
   wire [19:0] rp, wp, fs;
   wire [15:0] disp, dec, flags;
   wire [63:0] crop_o;
   wire [47:0] up;
   wire [4:0] wh;
   int n_errors = 0, n_compared = 0, cyc = 0, n_fill = 0, n_core = 0, n_start = 0, wh_m = 0, s0;
   dsoc_exp_t exp_q[$];
   dsoc_exp_t e;
   logic [59:0] ptr_q[$];
   logic [59:0] p;
   logic [15:0] flags_m = 0;
   logic [19:0] wr_m = 0, rd_m = 0;

   dsoc_ctrl i_dsoc_ctrl (.clk(clk), .rst(rst), .start_picture_decode(start), .fetch_decode_results(fetch),
      .query_stream_buffer(query), .advance_write_pointer(adv), .advance_bytes(adv_b),
      .report_stream_size(rep), .report_size(rep_b), .release_display_buffer(rel), .release_index(rel_i),
      .int_enable(int_en), .file_play_mode(fplay), .flush_mode(flush), .skip_picture(skip),
      .stream_end(send), .prescan_enable(pse), .prescan_mode(psm), .fill_valid(fill_v), .fill_data(fill_d),
      .fill_ready(fill_r), .core_valid(core_v), .core_data(core_d), .core_ready(core_r), .dp_start(dps),
      .dp_abort(dpa), .dp_target_index(tgt), .dp_done(dpd), .dp_full_picture(fullp), .dp_header_error(hdr),
      .dp_display_valid(dv), .dp_display_index(di), .dp_display_drained(drained), .dp_crop_on(crop_on),
      .dp_crop_offsets(crop), .dp_ps_short(ps), .dp_slice_short(sl), .query_valid(qv), .read_ptr(rp),
      .write_ptr(wp), .free_space(fs), .engine_busy_status(busy), .completion_irq(irq), .results_valid(rv),
      .display_buffer_index(disp), .decoded_buffer_index(dec), .full_picture_present(fpp),
      .crop_window_offsets(crop_o), .upcoming_buffer_indices(up), .ps_buffer_short(pss),
      .slice_buffer_short(sls), .display_flags(flags), .withheld_count(wh));
   dsoc_dp_model i_dsoc_dp_model (.clk(clk), .rst(rst), .dp_start(dps), .dp_abort(dpa), .dp_done(dpd),
      .core_ready(core_r), .slow(slow), .stall(stall));

   always #2 clk = ~clk;

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report

   // the run takes about 600 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_errors++;
         final_report();
      end
   end

   // watcher: counts handshakes, compares answers with the oldest note
   always @(posedge clk) begin
      if (dps) begin
         n_start++;
         `CHK("target", tgt_m, tgt)
      end
      if (fill_v && fill_r) n_fill++;
      if (core_v && core_r) begin
         n_core++;
         `CHK("core data", fill_d, core_d)
      end
      rv_d <= rv;
      // pop once: the compare macro names its expected value twice
      if (qv && ptr_q.size() > 0) begin
         p = ptr_q.pop_front();
         `CHK("pointers", p, {rp, wp, fs})
      end
      if (rv && !rv_d && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         `CHK("display", e.disp, disp)
         `CHK("decoded", e.dec, dec)
         `CHK("full picture", e.fp, fpp)
         `CHK("irq", e.irq, irq)
         `CHK("flags", e.flags, flags)
         if (e.full) begin
            `CHK("crop", e.crop, crop_o)
            `CHK("ps short", e.ps, pss)
            `CHK("slice short", e.sl, sls)
            `CHK("upcoming", e.up, up)
            `CHK("withheld", e.wh, wh)
         end
      end
   end

   function automatic logic [47:0] up3(input logic [15:0] f);
      logic [47:0] r;
      int n;
      r = {3{16'hFFFF}};
      n = 0;
      for (int b = 0; b < 16; b++) begin
         if (!f[b] && n < 3) begin
            r[n*16 +: 16] = 16'(b);
            n++;
         end
      end
      return r;
   endfunction : up3

   // host writes wrap at the end; the task does not limit them to the free space
   task automatic advance(input logic [19:0] b);
      // one idle edge so a second call never re-raises the strobe it just dropped
      @(posedge clk);
      #1 wr_m = (wr_m + b) & 20'h7FFFF;
      adv = 1;
      adv_b = b;
      @(posedge clk);
      #1 adv = 0;
   endtask : advance

   task automatic do_query;
      ptr_q.push_back({rd_m, wr_m, 20'h7FFFF - ((wr_m - rd_m) & 20'h7FFFF)});
      query = 1;
      @(posedge clk);
      #1 query = 0;
   endtask : do_query

   task automatic run_decode(input logic v, input logic [3:0] i);
      dsoc_exp_t x;
      logic early;
      int t;
      early = (flags_m == 16'hFFFF && !flush) || (pse && psm == PRESCAN_MODE_FULL_ONLY && !fullp);
      t = 0;
      while (t < 15 && flags_m[t]) t++;
      tgt_m = 4'(t);
      dv = v;
      di = i;
      crop = {$urandom, $urandom};
      crop_on = 1'($urandom);
      ps = 1'($urandom);
      sl = 1'($urandom);
      x.disp = early ? IDX_NOT_YET : v ? {12'h000, i} : (send && drained) ? IDX_END_OF_SEQ
         : skip ? IDX_FRAME_SKIP : IDX_NOT_YET;
      x.dec = (early || flush || skip || hdr) ? IDX_NO_DECODE : 16'(t);
      x.fp = !early && fullp;
      x.irq = int_en[IRQ_PIC_DONE_BIT];
      x.crop = crop_on ? crop : 64'h0;
      x.ps = ps;
      x.sl = sl;
      if (!early && v) flags_m[i] = 1'b1;
      x.flags = flags_m;
      x.up = up3(flags_m);
      // flushing decodes nothing, so it leaves the withheld count alone
      if (!early) wh_m = v ? 0 : flush ? wh_m : (wh_m < 17 ? wh_m + 1 : 17);
      x.wh = 5'(wh_m);
      x.full = !early;
      if (fplay) rd_m = wr_m;
      exp_q.push_back(x);
      start = 1;
      @(posedge clk);
      #1 start = 0;
      `CHK("busy", 1'b1, busy)
      for (t = 0; t < 300 && rv !== 1'b1; t++) begin
         @(posedge clk);
         #1;
      end
      `CHK("busy at done", 1'b0, busy)
      // a start before the fetch must be ignored
      start = 1;
      @(posedge clk);
      #1 start = 0;
      @(posedge clk);
      #1 `CHK("busy refused", 1'b0, busy)
      fetch = 1;
      @(posedge clk);
      #1 fetch = 0;
      `CHK("irq after fetch", 1'b0, irq)
   endtask : run_decode

   initial begin
      void'($urandom(32'h4AF0));
      repeat (10) @(posedge clk);
      #1 rst = 0;
      `CHK("reset display", IDX_NOT_YET, disp)
      `CHK("reset decoded", IDX_NO_DECODE, dec)
      `CHK("reset busy irq", 2'b00, {busy, irq})
      `CHK("reset flags", 16'h0000, flags)
      advance(20'h7FFF0);
      advance(20'h00020);
      do_query();
      advance(20'h01000);
      // fill the fifo with the datapath stalled, then let it drain
      slow = 1;
      stall = 1;
      fork
         run_decode(1'b1, 4'h5);
         begin
            repeat (4) @(posedge clk);
            #1 fill_v = 1;
            fill_d = $urandom;
            repeat (40) @(posedge clk);
            #1 fill_v = 0;
            `CHK("words accepted", FIFO_DEPTH, n_fill)
            stall = 0;
         end
      join
      slow = 0;
      `CHK("words drained", FIFO_DEPTH, n_core)
      rd_m = rd_m + 20'(4 * n_fill);
      do_query();
      int_en = 8'hF7;
      run_decode(1'b1, 4'h3);
      int_en = 8'h08;
      for (int m = 0; m < 4; m++) begin
         send = (m == 0);
         drained = (m == 0);
         skip = (m == 1);
         hdr = (m == 2);
         flush = (m == 3);
         run_decode(1'b0, 4'h0);
      end
      {send, drained, skip, hdr, flush} = 5'h00;
      for (int k = 0; k < 18; k++) run_decode(1'b0, 4'h0);
      pse = 1;
      fullp = 0;
      run_decode(1'b1, 4'h9);
      pse = 0;
      fullp = 1;
      for (int k = 0; k < 16; k++) run_decode(1'b1, 4'(k));
      s0 = n_start;
      run_decode(1'b1, 4'h2);
      `CHK("no datapath start", s0, n_start)
      rel = 1;
      rel_i = 4'h7;
      flags_m[7] = 1'b0;
      @(posedge clk);
      #1 rel = 0;
      run_decode(1'b0, 4'h0);
      fplay = 1;
      advance(20'h00100);
      run_decode(1'b0, 4'h0);
      do_query();
      fplay = 0;
      slow = 1;
      fork
         run_decode(1'b1, 4'hA);
         begin
            repeat (6) @(posedge clk);
            #1 rep = 1;
            @(posedge clk);
            #1 rep = 0;
            @(posedge clk);
            #1 `CHK("prompt end", 1'b1, rv)
         end
      join
      `CHK("notes left", 0, exp_q.size() + ptr_q.size())
      final_report();
   end
`undef CHK
endmodule : test_decoder_stream_and_output_control
`default_nettype wire
